//--- common/psd_defines.svh
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH

// -------------------------------------------------------------
// Register indices and byte addresses
// -------------------------------------------------------------
`define PSD_IDX_MODE 8'h77
`define PSD_IDX_MASK 8'h78
`define PSD_IDX_SEED 8'h80
`define PSD_IDX_EARLY 8'h84
`define PSD_ADDR_MODE 12'h1DC
`define PSD_ADDR_MASK 12'h1E0
`define PSD_ADDR_SEED 12'h200
`define PSD_ADDR_EARLY 12'h210

// -------------------------------------------------------------
// Field widths and positions
// -------------------------------------------------------------
`define PSD_MODE_BIT 0
`define PSD_MASK_W 17
`define PSD_SEED_W 17
`define PSD_EARLY_W 16
`define PSD_PORT_W 5
`define PSD_SEED_PAUSE_LSB 15
`define PSD_SEED_SIGDET_BIT 1
`define PSD_SEED_PAUSE_MSB 16
`define PSD_SEED_HALF_BIT 14
`define PSD_SEED_FULL_BIT 13
`define PSD_SEED_TENBIT_BIT 12
`define PSD_SEED_FIBER_BIT 11
`define PSD_SEED_CLKOFF_BIT 10
`define PSD_SEED_DEPTH_MSB 9
`define PSD_SEED_DEPTH_LSB 8
`define PSD_SEED_FLOCK_BIT 7
`define PSD_SEED_AUTO_BIT 6
`define PSD_SEED_PARDET_BIT 5
`define PSD_SEED_EXTCRS_BIT 4
`define PSD_SEED_INVCRS_BIT 3
`define PSD_SEED_SPARE2_BIT 2
`define PSD_SEED_SPARE0_BIT 0

// -------------------------------------------------------------
// Reset values
// -------------------------------------------------------------
`define PSD_RST_MODE 1'h0
`define PSD_RST_MASK 17'h0
`define PSD_RST_SEED 17'h6460
`define PSD_RST_EARLY 16'h0

`endif

//--- common/psd_pkg.sv
`default_nettype none

`include "psd_defines.svh"

package psd_pkg;

   // Received frame presented for the admission check
   typedef struct packed {
      logic valid;
      logic [`PSD_PORT_W-1:0] port;
      logic saHit;
      logic special;
   } psd_frame_s;

   // Admission verdict, one cycle after the frame
   typedef struct packed {
      logic valid;
      logic [`PSD_PORT_W-1:0] port;
      logic drop;
   } psd_verdict_s;

   // Transceiver seed word, bit 16 down to bit 0
   typedef struct packed {
      logic [1:0] pauseAdvert;
      logic advHalfDuplex;
      logic advFullDuplex;
      logic tenBitMode;
      logic fiberMode;
      logic refClockOutOffSeed;
      logic [1:0] elasticDepth;
      logic freqLockTx;
      logic autoDetect;
      logic parallelDetect;
      logic useExtPhyCrs;
      logic invertExtPhyCrs;
      logic spareBit2;
      logic signalDetectEnableSeed;
      logic spareBit0;
   } psd_seed_s;

   // Bus access outcome
   typedef enum logic [1:0] {
      PSD_ACC_NONE = 2'b00,
      PSD_ACC_READ = 2'b01,
      PSD_ACC_WRITE = 2'b10
   } psd_access_e;

endpackage

`default_nettype wire

//--- hw/psd_port_security_serdes_defaults_regs.sv
`default_nettype none

`include "psd_defines.svh"

// Behaviour
// RQ1: Mode 0, secured port: drop frame when source address misses and not special.
// RQ2: Mode 1, secured port: drop every frame that is not special.
// RQ3: Seventeen-bit RW per-port security enable mask, all zero after reset.
// RQ4: Seventeen-bit RW seed word, reset 17'h6460, feeds every transceiver core.
// RQ5: Seed bits 16:15 are pause advertisement, reset 2'b00.
// RQ6: Seed bit 14 half-duplex, bit 13 full-duplex advertisement, both reset 1.
// RQ7: Seed bit 12 ten-bit mode, bit 11 fiber mode, both reset 0.
// RQ8: Seed bit 10 turns reference clock output off, reset 1.
// RQ9: Seed bits 9:8 are elastic buffer depth, reset 2'b00.
// RQ10: Seed bit 7 is transmit frequency lock, reset 0.
// RQ11: Seed bit 6 auto mode detect, bit 5 parallel detect, both reset 1.
// RQ12: Seed bit 4 uses external carrier sense, bit 3 inverts it, reset 0.
// RQ13: Seed bit 1 is signal-detect enable, reset 0.
// RQ14: Sixteen-bit RW carrier select, 0 regular, 1 early, reset zero.
// RQ15: Early carrier sense and collision come from external PHY carrier sense.
// RQ16: Reserved bits read zero and ignore writes.
module psd_port_security_serdes_defaults_regs
   import psd_pkg::*;
#(
   parameter int NUM_PORTS = 17,
   parameter int NUM_LINK_PORTS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frame admission
   input wire psd_frame_s frameIn,
   output psd_verdict_s verdictOut,
   // Transceiver seed
   output psd_seed_s seedOut,
   // Carrier sense and collision per link port
   input wire logic [NUM_LINK_PORTS-1:0] regularCrs,
   input wire logic [NUM_LINK_PORTS-1:0] regularCol,
   input wire logic [NUM_LINK_PORTS-1:0] extPhyCrs,
   input wire logic [NUM_LINK_PORTS-1:0] txActive,
   output logic [NUM_LINK_PORTS-1:0] crsOut,
   output logic [NUM_LINK_PORTS-1:0] colOut
);

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------

   // Merge write data into a stored word under byte strobes
   // A lane whose strobe is low keeps the stored byte untouched
   function automatic logic [31:0] merge_bytes(input logic [31:0] oldWord,
                                                input logic [31:0] newWord,
                                                input logic [3:0] strobes);
      logic [31:0] result;
      result = oldWord;
      for (int i = 0; i < 4; i++) begin
         if (strobes[i]) begin
            result[i*8 +: 8] = newWord[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // True when the address hits one of the four registers
   // An unmapped access answers with an error and changes nothing
   function automatic logic addr_mapped(input logic [11:0] addr);
      return (addr == `PSD_ADDR_MODE) || (addr == `PSD_ADDR_MASK) ||
             (addr == `PSD_ADDR_SEED) || (addr == `PSD_ADDR_EARLY);
   endfunction

   // ----------------------------------------------------------
   // Register state
   // ----------------------------------------------------------
   // Only documented bits and seed spare bits 2 and 0 have storage; other reserved bits have no flop at all
   logic frameAdmitMode;
   logic [`PSD_MASK_W-1:0] portSecurityEnableMask;
   logic [`PSD_SEED_W-1:0] transceiverDefaultWord;
   logic [`PSD_EARLY_W-1:0] earlyCarrierCollisionSelect;

   psd_access_e access;
   logic [31:0] next_modeWord;
   logic [31:0] next_maskWord;
   logic [31:0] next_seedWord;
   logic [31:0] next_earlyWord;
   logic [31:0] readWord;
   logic modeWrite;
   logic maskWrite;
   logic seedWrite;
   logic earlyWrite;

   // ----------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------

   // Writes land only at the completing access edge
   always_comb begin
      if (psel && penable && pready) begin
         access = pwrite ? PSD_ACC_WRITE : PSD_ACC_READ;
      end else begin
         access = PSD_ACC_NONE;
      end
   end

   // Byte-lane merge of each register against its current value
   assign next_modeWord = merge_bytes({31'h0, frameAdmitMode}, pwdata, pstrb);
   assign next_maskWord = merge_bytes({15'h0, portSecurityEnableMask}, pwdata, pstrb);
   assign next_seedWord = merge_bytes({15'h0, transceiverDefaultWord}, pwdata, pstrb);
   assign next_earlyWord = merge_bytes({16'h0, earlyCarrierCollisionSelect}, pwdata, pstrb);

   // One strobe per register; an unmapped address raises none of them,
   // so a refused write cannot touch any stored bit
   assign modeWrite = (access == PSD_ACC_WRITE) && (paddr == `PSD_ADDR_MODE);
   assign maskWrite = (access == PSD_ACC_WRITE) && (paddr == `PSD_ADDR_MASK);
   assign seedWrite = (access == PSD_ACC_WRITE) && (paddr == `PSD_ADDR_SEED);
   assign earlyWrite = (access == PSD_ACC_WRITE) && (paddr == `PSD_ADDR_EARLY);

   // RQ16 reserved read zero
   // Read mux; upper bits are not stored, so they read as zero for free
   always_comb begin
      case (paddr)
         `PSD_ADDR_MODE: readWord = {31'h0, frameAdmitMode};
         `PSD_ADDR_MASK: readWord = {15'h0, portSecurityEnableMask};
         `PSD_ADDR_SEED: readWord = {15'h0, transceiverDefaultWord};
         `PSD_ADDR_EARLY: readWord = {16'h0, earlyCarrierCollisionSelect};
         default: readWord = 32'h0;
      endcase
   end

   // ----------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------

   // Zero wait states: ready is raised for the cycle after setup.
   // Registering it keeps the answer off any path from the bus inputs;
   // the price is an access phase of exactly one cycle, never shorter.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'h0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // Read data is captured during setup and stands through the access cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0 : readWord;
      end
   end

   // Error flag rides with ready: set for one access cycle, cleared after
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pslverr <= 1'h0;
      end else if (psel && !penable) begin
         pslverr <= !addr_mapped(paddr);
      end else begin
         pslverr <= 1'h0;
      end
   end

   // ----------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------

   // RQ16 reserved bits dropped
   // Only bit 0 is kept; bits 7:1 of the written byte go nowhere
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frameAdmitMode <= `PSD_RST_MODE;
      end else if (modeWrite) begin
         frameAdmitMode <= next_modeWord[`PSD_MODE_BIT];
      end
   end

   // RQ16 upper bits ignored
   // RQ3 security enable mask
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         portSecurityEnableMask <= `PSD_RST_MASK;
      end else if (maskWrite) begin
         portSecurityEnableMask <= next_maskWord[`PSD_MASK_W-1:0];
      end
   end

   // RQ16 upper bits ignored
   // RQ4 seed word reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         transceiverDefaultWord <= `PSD_RST_SEED;
      end else if (seedWrite) begin
         transceiverDefaultWord <= next_seedWord[`PSD_SEED_W-1:0];
      end
   end

   // RQ14 carrier select register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         earlyCarrierCollisionSelect <= `PSD_RST_EARLY;
      end else if (earlyWrite) begin
         earlyCarrierCollisionSelect <= next_earlyWord[`PSD_EARLY_W-1:0];
      end
   end

   // ----------------------------------------------------------
   // Frame admission
   // ----------------------------------------------------------
   logic portSecured;
   logic next_drop;

   // Ports beyond the mask are never secured
   // The range test comes first so no index past the mask is ever used
   assign portSecured = (int'(frameIn.port) < NUM_PORTS) &&
                        portSecurityEnableMask[frameIn.port];

   // Special frames always pass; the mode picks the rest
   always_comb begin
      next_drop = 1'b0;
      if (portSecured && !frameIn.special) begin
         if (frameAdmitMode) begin
            // RQ2 drop all others
            next_drop = 1'b1;
         end else begin
            // RQ1 drop on miss
            next_drop = !frameIn.saHit;
         end
      end
   end

   // Verdict is registered one cycle after the request
   // Drop is gated by valid so an idle cycle never reports a drop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         verdictOut <= '0;
      end else begin
         verdictOut.valid <= frameIn.valid;
         verdictOut.port <= frameIn.port;
         verdictOut.drop <= frameIn.valid && next_drop;
      end
   end

   // ----------------------------------------------------------
   // Transceiver seed distribution
   // ----------------------------------------------------------

   // Copied field by field: consumers read seed bits by name, so each name
   // is tied to its bit position here rather than by struct order alone
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seedOut <= psd_seed_s'(`PSD_RST_SEED);
      end else begin
         // RQ5 pause advertisement
         seedOut.pauseAdvert <=
            transceiverDefaultWord[`PSD_SEED_PAUSE_MSB:`PSD_SEED_PAUSE_LSB];
         // RQ6 duplex advertisement
         seedOut.advHalfDuplex <= transceiverDefaultWord[`PSD_SEED_HALF_BIT];
         seedOut.advFullDuplex <= transceiverDefaultWord[`PSD_SEED_FULL_BIT];
         // RQ7 interface modes
         seedOut.tenBitMode <= transceiverDefaultWord[`PSD_SEED_TENBIT_BIT];
         seedOut.fiberMode <= transceiverDefaultWord[`PSD_SEED_FIBER_BIT];
         // RQ8 clock output off
         seedOut.refClockOutOffSeed <= transceiverDefaultWord[`PSD_SEED_CLKOFF_BIT];
         // RQ9 elastic depth
         seedOut.elasticDepth <=
            transceiverDefaultWord[`PSD_SEED_DEPTH_MSB:`PSD_SEED_DEPTH_LSB];
         // RQ10 frequency lock
         seedOut.freqLockTx <= transceiverDefaultWord[`PSD_SEED_FLOCK_BIT];
         // RQ11 detection modes
         seedOut.autoDetect <= transceiverDefaultWord[`PSD_SEED_AUTO_BIT];
         seedOut.parallelDetect <= transceiverDefaultWord[`PSD_SEED_PARDET_BIT];
         // RQ12 external carrier sense
         seedOut.useExtPhyCrs <= transceiverDefaultWord[`PSD_SEED_EXTCRS_BIT];
         seedOut.invertExtPhyCrs <= transceiverDefaultWord[`PSD_SEED_INVCRS_BIT];
         // RQ13 signal detect
         seedOut.signalDetectEnableSeed <= transceiverDefaultWord[`PSD_SEED_SIGDET_BIT];
         // Spare positions are stored and passed on, unused downstream
         seedOut.spareBit2 <= transceiverDefaultWord[`PSD_SEED_SPARE2_BIT];
         seedOut.spareBit0 <= transceiverDefaultWord[`PSD_SEED_SPARE0_BIT];
      end
   end

   // ----------------------------------------------------------
   // Carrier sense and collision select
   // ----------------------------------------------------------
   logic [NUM_LINK_PORTS-1:0] earlyCrs;
   logic [NUM_LINK_PORTS-1:0] earlyCol;

   // RQ15 early from external
   // Collision is carrier seen while this port transmits
   assign earlyCrs = extPhyCrs;
   assign earlyCol = extPhyCrs & txActive;

   // Per-port selection; a flop keeps the outputs glitch free
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         crsOut <= '0;
      end else begin
         // RQ14 per-port select
         for (int p = 0; p < NUM_LINK_PORTS; p++) begin
            crsOut[p] <= earlyCarrierCollisionSelect[p] ? earlyCrs[p] : regularCrs[p];
         end
      end
   end

   // Collision follows the same select bit as carrier for its port, so the
   // two never come from different sources on one port
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         colOut <= '0;
      end else begin
         // RQ14 per-port select
         for (int p = 0; p < NUM_LINK_PORTS; p++) begin
            colOut[p] <= earlyCarrierCollisionSelect[p] ? earlyCol[p] : regularCol[p];
         end
      end
   end

endmodule

`default_nettype wire

//--- verification/psd_regs_props.sv
`default_nettype none
`include "psd_defines.svh"
module psd_regs_props
   import psd_pkg::*;
#(
   parameter int NUM_LINK_PORTS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Frame path and seed
   input wire psd_frame_s frameIn,
   input wire psd_verdict_s verdictOut,
   input wire psd_seed_s seedOut,
   // Carrier path
   input wire logic [NUM_LINK_PORTS-1:0] regularCrs,
   input wire logic [NUM_LINK_PORTS-1:0] regularCol,
   input wire logic [NUM_LINK_PORTS-1:0] extPhyCrs,
   input wire logic [NUM_LINK_PORTS-1:0] txActive,
   input wire logic [NUM_LINK_PORTS-1:0] crsOut,
   input wire logic [NUM_LINK_PORTS-1:0] colOut
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic mapped;

   // Decode of the four slots; anything else must be refused
   assign mapped = paddr == `PSD_ADDR_MODE || paddr == `PSD_ADDR_MASK ||
                   paddr == `PSD_ADDR_SEED || paddr == `PSD_ADDR_EARLY;

   a_ready_once:
      assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   a_unmapped_err:
      assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok:
      assert property (psel && !penable && mapped |=> !pslverr)
      else $error("mapped access refused");
   a_mode_spare:
      assert property (pready && !pwrite && paddr == `PSD_ADDR_MODE |-> prdata[31:1] == 0)
      else $error("mode spare bits not zero");
   a_wide_spare:
      assert property (pready && !pwrite && (paddr == `PSD_ADDR_MASK ||
         paddr == `PSD_ADDR_SEED) |-> prdata[31:17] == 0)
      else $error("mask or seed spare bits not zero");
   a_select_spare:
      assert property (pready && !pwrite && paddr == `PSD_ADDR_EARLY |-> prdata[31:16] == 0)
      else $error("select spare bits not zero");
   a_verdict_port:
      assert property (frameIn.valid |=> verdictOut.valid &&
         verdictOut.port == $past(frameIn.port))
      else $error("verdict missing or wrong port");
   a_special_kept:
      assert property (frameIn.valid && frameIn.special |=> !verdictOut.drop)
      else $error("special frame dropped");
   a_no_frame:
      assert property (!frameIn.valid |=> !verdictOut.valid && !verdictOut.drop)
      else $error("verdict without frame");
   a_seed_write:
      assert property ($changed(seedOut) |-> $past(pready, 2) && $past(pwrite, 2))
      else $error("seed moved without a write");
   a_crs_path:
      assert property ($past(rst_n) && $past(regularCrs) == $past(extPhyCrs)
         |-> crsOut == $past(regularCrs))
      else $error("carrier out not from its sources");
   a_col_quiet:
      assert property ($past(rst_n) && $past(regularCol) == 0 &&
         ($past(extPhyCrs) & $past(txActive)) == 0 |-> colOut == 0)
      else $error("collision out without a cause");
endmodule

bind psd_port_security_serdes_defaults_regs psd_regs_props #(
   .NUM_LINK_PORTS(NUM_LINK_PORTS)
) psd_regs_props_i (
   .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .frameIn, .verdictOut, .seedOut, .regularCrs, .regularCol,
   .extPhyCrs, .txActive, .crsOut, .colOut
);
`default_nettype wire

//--- verification/tb_psd_port_security_serdes_defaults_regs.sv
`default_nettype none
`include "psd_defines.svh"
module tb_psd_port_security_serdes_defaults_regs;
   import psd_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   psd_frame_s frameIn;
   psd_verdict_s verdictOut;
   psd_seed_s seedOut;
   logic [15:0] regularCrs, regularCol, extPhyCrs, txActive, crsOut, colOut;
   int failCount, numChecks;

   psd_port_security_serdes_defaults_regs psd_port_security_serdes_defaults_regs_i (
      .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .frameIn, .verdictOut, .seedOut, .regularCrs,
      .regularCol, .extPhyCrs, .txActive, .crsOut, .colOut);

   // Core clock, 10 ns period
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, got);
      numChecks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         failCount++;
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Bus master; holds the request until ready is seen, bounded wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 20) begin
         failCount++;
         wrap_up();
      end
   endtask

   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   // One frame in, verdict judged the cycle after
   task automatic frm(input logic [4:0] p, input logic hit, sp, dr);
      @(posedge clk);
      frameIn <= {1'h1, p, hit, sp};
      @(posedge clk);
      frameIn <= '0;
      #1;
      chk("verdict", {1'h1, p, dr}, verdictOut);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rchk("mode", `PSD_ADDR_MODE, 32'h0);
      rchk("mask", `PSD_ADDR_MASK, 32'h0);
      rchk("seed", `PSD_ADDR_SEED, 32'h6460);
      rchk("select", `PSD_ADDR_EARLY, 32'h0);
      chk("seed out", 32'h6460, seedOut);
      chk("pause", 32'h0, seedOut.pauseAdvert);
      chk("half", 32'h1, seedOut.advHalfDuplex);
      chk("full", 32'h1, seedOut.advFullDuplex);
      chk("ten bit", 32'h0, seedOut.tenBitMode);
      chk("fiber", 32'h0, seedOut.fiberMode);
      chk("clk off", 32'h1, seedOut.refClockOutOffSeed);
      chk("depth", 32'h0, seedOut.elasticDepth);
      chk("flock", 32'h0, seedOut.freqLockTx);
      chk("auto", 32'h1, seedOut.autoDetect);
      chk("parallel", 32'h1, seedOut.parallelDetect);
      chk("ext crs", 32'h0, seedOut.useExtPhyCrs);
      chk("inv crs", 32'h0, seedOut.invertExtPhyCrs);
      chk("sig det", 32'h0, seedOut.signalDetectEnableSeed);
      $display("reset test done");
   endtask

   // All-ones writes expose spare bits; a one-lane write touches only byte 0
   task automatic t_regs();
      apb(1'h1, `PSD_ADDR_MODE, 32'hFFFFFFFF);
      rchk("mode w", `PSD_ADDR_MODE, 32'h1);
      apb(1'h1, `PSD_ADDR_MASK, 32'hFFFFFFFF);
      rchk("mask w", `PSD_ADDR_MASK, 32'h1FFFF);
      apb(1'h1, `PSD_ADDR_SEED, 32'hFFFFFFFF);
      apb(1'h1, `PSD_ADDR_SEED, 32'h0, 4'h1);
      rchk("seed w", `PSD_ADDR_SEED, 32'h1FF00);
      chk("seed out w", 32'h1FF00, seedOut);
      chk("pause w", 32'h3, seedOut.pauseAdvert);
      apb(1'h1, `PSD_ADDR_SEED, 32'h2);
      rchk("seed sd", `PSD_ADDR_SEED, 32'h2);
      chk("sd seed", 32'h1, seedOut.signalDetectEnableSeed);
      chk("clk off w", 32'h0, seedOut.refClockOutOffSeed);
      apb(1'h1, `PSD_ADDR_EARLY, 32'hFFFFFFFF);
      apb(1'h1, 12'h204, 32'h0);
      chk("werr", 32'h1, er);
      rchk("unmapped", 12'h204, 32'h0);
      chk("rerr", 32'h1, er);
      rchk("select w", `PSD_ADDR_EARLY, 32'hFFFF);
      $display("register test done");
   endtask

   task automatic t_admit();
      frm(5'h10, 1'h1, 1'h0, 1'h1);
      apb(1'h1, `PSD_ADDR_MASK, 32'h8);
      apb(1'h1, `PSD_ADDR_MODE, 32'h0);
      frm(5'h3, 1'h0, 1'h0, 1'h1);
      frm(5'h3, 1'h1, 1'h0, 1'h0);
      frm(5'h3, 1'h0, 1'h1, 1'h0);
      frm(5'h5, 1'h0, 1'h0, 1'h0);
      apb(1'h1, `PSD_ADDR_MODE, 32'h1);
      frm(5'h3, 1'h1, 1'h0, 1'h1);
      frm(5'h3, 1'h1, 1'h1, 1'h0);
      $display("admission test done");
   endtask

   // Low byte of ports on early path, high byte regular
   task automatic t_early();
      apb(1'h1, `PSD_ADDR_EARLY, 32'h0);
      repeat (2) @(posedge clk);
      #1;
      chk("crs reg", 32'hA5A5, crsOut);
      chk("col reg", 32'h0F0F, colOut);
      apb(1'h1, `PSD_ADDR_EARLY, 32'h00FF);
      repeat (2) @(posedge clk);
      #1;
      chk("crs mix", 32'hA55A, crsOut);
      chk("col mix", 32'h0F50, colOut);
      @(posedge clk);
      regularCol <= 16'h0;
      txActive <= 16'h0;
      extPhyCrs <= 16'hA5A5;
      repeat (2) @(posedge clk);
      #1;
      chk("crs same", 32'hA5A5, crsOut);
      chk("col idle", 32'h0, colOut);
      $display("carrier test done");
   endtask

   // Reset in mid-run must bring every register back to its default
   task automatic t_rerun();
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      rchk("mode rst", `PSD_ADDR_MODE, 32'h0);
      rchk("mask rst", `PSD_ADDR_MASK, 32'h0);
      rchk("seed rst", `PSD_ADDR_SEED, 32'h6460);
      rchk("select rst", `PSD_ADDR_EARLY, 32'h0);
      $display("second reset test done");
   endtask

   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      frameIn = '0;
      regularCrs = 16'hA5A5;
      regularCol = 16'h0F0F;
      extPhyCrs = 16'h5A5A;
      txActive = 16'h0FF0;
      failCount = 0;
      numChecks = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      t_reset();
      t_regs();
      t_admit();
      t_early();
      t_rerun();
      wrap_up();
   end
endmodule
`default_nettype wire
